/* File: hw/uce_baud.v */
// Oversample tick generator, sixteen ticks per bit
module uce_baud #(
    parameter W = 16
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] divisor,
    output reg tick
);
    reg [W-1:0] cnt_q;
    wire [W-1:0] last;

    // Divisor zero behaves as one
    assign last = (divisor == {W{1'b0}}) ? {W{1'b0}} : divisor - 1'b1;

    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= {W{1'b0}};
            tick <= 1'b0;
        end else if (cnt_q >= last) begin
            cnt_q <= {W{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule // uce_baud

/* File: hw/uce_consts.vh */
// Register indices, field positions and timing counts of the serial block
`ifndef UCE_CONSTS_VH
`define UCE_CONSTS_VH
// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define UCE_ADDR_W 14
`define UCE_IDX_DATA 12'hf40
`define UCE_IDX_STAT 12'hf41
`define UCE_IDX_CTLA 12'hf42
`define UCE_IDX_CTLB 12'hf43
`define UCE_IDX_BAUDH 12'hf44
`define UCE_IDX_BAUDL 12'hf45
`define UCE_IDX_ADRCMP 12'hf46
// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define UCE_CTLA_RST 8'h00
`define UCE_CTLB_RST 8'h00
`define UCE_BAUD_RST 16'h0001
`define UCE_ADRCMP_RST 8'h00
// ------------------------------------------------------------------
// Field positions of serial_control_a
// ------------------------------------------------------------------
`define UCE_A_TX_ON 7
`define UCE_A_RX_ON 6
`define UCE_A_CTS_GATE 5
`define UCE_A_PARITY_ON 4
`define UCE_A_PARITY_ODD 3
`define UCE_A_BREAK 2
`define UCE_A_STOP2 1
`define UCE_A_LOOPBACK 0
// ------------------------------------------------------------------
// Field positions of serial_control_b and status
// ------------------------------------------------------------------
`define UCE_B_MULTIDROP_ON 7
`define UCE_B_KIND_HI 6
`define UCE_B_KIND_LO 5
`define UCE_B_ERR_ONLY 4
`define UCE_B_TX_ADDR_BIT 3
`define UCE_B_INFRARED 1
`define UCE_S_RX_AVAIL 0
`define UCE_S_TX_EMPTY 1
`define UCE_S_TX_IDLE 2
`define UCE_S_RX_ADDR 3
`define UCE_S_PAR_ERR 4
`define UCE_S_FRM_ERR 5
`define UCE_S_OVERRUN 6
// ------------------------------------------------------------------
// Timing counts in oversample ticks
// ------------------------------------------------------------------
`define UCE_OVS_LAST 4'hf
`define UCE_MID_BIT 4'h7
`define UCE_IR_PULSE 4'h3
`define UCE_IR_BIT 5'h10
`define UCE_IR_WIN_END 5'h18
`endif

/* File: hw/uce_ir_codec.v */
// Infrared pulse encoder and decoder placed between line and shifters
`include "uce_consts.vh"
module uce_ir_codec (
    input wire clk,
    input wire rst,
    input wire tick,
    input wire enable,
    input wire tx_bit,
    input wire [3:0] tx_phase,
    input wire rx_pin,
    output wire tx_pin,
    output wire rx_bit
);
    reg rx_prev_q;
    reg active_q;
    reg dec_out_q;
    reg [4:0] cnt_q;
    wire fall;

    // ------------------------------------------------------------------
    // Encoder: short high pulse for each zero bit
    // ------------------------------------------------------------------
    assign tx_pin = enable ? (~tx_bit & (tx_phase < `UCE_IR_PULSE)) : tx_bit;
    assign rx_bit = enable ? dec_out_q : rx_pin;
    assign fall = rx_prev_q & ~rx_pin;

    // ------------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rx_prev_q <= 1'b1;
            active_q <= 1'b0;
            dec_out_q <= 1'b1;
            cnt_q <= 5'h00;
        end else begin
            rx_prev_q <= rx_pin;
            if (enable && fall) begin
                cnt_q <= 5'h00;
                active_q <= 1'b1;
                dec_out_q <= 1'b0;
            end else if (active_q && tick) begin
                if (cnt_q == `UCE_IR_WIN_END) begin
                    active_q <= 1'b0;
                    dec_out_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 5'h01;
                    dec_out_q <= ((cnt_q + 5'h01) < `UCE_IR_BIT) ? 1'b0 : 1'b1;
                end
            end else if (!enable) begin
                active_q <= 1'b0;
                dec_out_q <= 1'b1;
            end
        end
    end
endmodule // uce_ir_codec

/* File: hw/uce_serial_ctl.v */
// Serial transceiver with infrared codec and Avalon-MM register slave
`include "uce_consts.vh"
module uce_serial_ctl (
    input wire CLK,
    input wire RESET,
    input wire [`UCE_ADDR_W-1:0] ADDRESS,
    input wire READ,
    input wire WRITE,
    input wire [31:0] WRITEDATA,
    input wire [3:0] BYTEENABLE,
    output reg [31:0] READDATA,
    output reg WAITREQUEST,
    input wire RXD,
    input wire CTS_N,
    output reg TXD,
    output reg RX_IRQ
);
    localparam TX_IDLE = 3'd0;
    localparam TX_START = 3'd1;
    localparam TX_DATA = 3'd2;
    localparam TX_EXTRA = 3'd3;
    localparam TX_STOP = 3'd4;
    localparam RX_IDLE = 3'd0;
    localparam RX_START = 3'd1;
    localparam RX_DATA = 3'd2;
    localparam RX_EXTRA = 3'd3;
    localparam RX_STOP = 3'd4;

    function hit;
        input [`UCE_ADDR_W-1:0] addr;
        input [11:0] idx;
        begin
            hit = (addr == {idx, 2'b00});
        end
    endfunction

    reg [7:0] ctla_q;
    reg [7:0] ctlb_q;
    reg [15:0] baud_q;
    reg [7:0] adrcmp_q;
    reg [7:0] tx_hold_q;
    reg tx_full_q;
    reg [2:0] tx_state_q;
    reg [3:0] tx_phase_q;
    reg [2:0] tx_idx_q;
    reg [7:0] tx_shift_q;
    reg tx_extra_q;
    reg tx_stop_n_q;
    reg [2:0] rx_state_q;
    reg [3:0] rx_phase_q;
    reg [2:0] rx_idx_q;
    reg [7:0] rx_shift_q;
    reg rx_extra_q;
    reg [7:0] rx_data_q;
    reg rx_addr_q;
    reg rx_avail_q;
    reg par_err_q;
    reg frm_err_q;
    reg ovr_q;
    reg matched_q;
    wire [1:0] stable_q;
    reg tx_line;
    reg deliver;
    reg [7:0] rd_val;
    wire tick;
    wire tx_go;
    wire bit_end;
    wire rx_sample;
    wire codec_tx;
    wire rx_bit;
    wire [1:0] pins;
    wire need_extra;
    wire wr_take;
    wire rd_take;
    wire rx_done;
    wire rx_pin;
    wire [1:0] kind;

    wire tx_on = ctla_q[`UCE_A_TX_ON];
    wire rx_on = ctla_q[`UCE_A_RX_ON];
    wire par_on = ctla_q[`UCE_A_PARITY_ON];
    wire par_odd = ctla_q[`UCE_A_PARITY_ODD];
    wire brk = ctla_q[`UCE_A_BREAK];
    wire md_on = ctlb_q[`UCE_B_MULTIDROP_ON];

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    assign pins = {CTS_N, RXD};
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_sync
            reg [2:0] sync_q;
            reg hold_q;
            always @(posedge CLK) begin
                if (RESET) begin
                    sync_q <= 3'b111;
                    hold_q <= 1'b1;
                end else begin
                    sync_q <= {sync_q[1:0], pins[g]};
                    if (sync_q[1] == sync_q[2]) begin
                        hold_q <= sync_q[2];
                    end
                end
            end
            assign stable_q[g] = hold_q;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Baud ticks and infrared codec
    // ------------------------------------------------------------------
    uce_baud #(.W(16)) u_baud (
        .clk(CLK),
        .rst(RESET),
        .divisor(baud_q),
        .tick(tick)
    );

    assign rx_pin = ctla_q[`UCE_A_LOOPBACK] ? TXD : stable_q[0];

    uce_ir_codec u_ir (
        .clk(CLK),
        .rst(RESET),
        .tick(tick),
        .enable(ctlb_q[`UCE_B_INFRARED]),
        .tx_bit(tx_line),
        .tx_phase(tx_phase_q),
        .rx_pin(rx_pin),
        .tx_pin(codec_tx),
        .rx_bit(rx_bit)
    );

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    // transmitter enable
    assign tx_go = tx_on & (~ctla_q[`UCE_A_CTS_GATE] | ~stable_q[1]);
    assign bit_end = tick & (tx_phase_q == `UCE_OVS_LAST);
    assign need_extra = par_on | md_on;

    always @* begin
        case (tx_state_q)
            TX_START: tx_line = 1'b0;
            TX_DATA: tx_line = tx_shift_q[0];
            TX_EXTRA: tx_line = tx_extra_q;
            default: tx_line = 1'b1;
        endcase
    end

    always @(posedge CLK) begin
        if (RESET) begin
            tx_state_q <= TX_IDLE;
            tx_phase_q <= 4'h0;
            tx_idx_q <= 3'd0;
            tx_shift_q <= 8'h00;
            tx_extra_q <= 1'b0;
            tx_stop_n_q <= 1'b0;
            TXD <= 1'b1;
        end else begin
            TXD <= brk ? 1'b0 : codec_tx;
            if (tick) begin
                tx_phase_q <= tx_phase_q + 4'h1;
            end
            if (brk) begin
                tx_state_q <= TX_IDLE;
            end else begin
                case (tx_state_q)
                    TX_IDLE: begin
                        tx_phase_q <= 4'h0;
                        if (tx_full_q && tx_go) begin
                            tx_shift_q <= tx_hold_q;
                            tx_idx_q <= 3'd0;
                            tx_extra_q <= par_on ? (^tx_hold_q ^ par_odd)
                                : ctlb_q[`UCE_B_TX_ADDR_BIT];
                            tx_stop_n_q <= ctla_q[`UCE_A_STOP2];
                            tx_state_q <= TX_START;
                        end
                    end
                    TX_START: begin
                        if (bit_end) begin
                            tx_state_q <= TX_DATA;
                        end
                    end
                    TX_DATA: begin
                        if (bit_end) begin
                            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                            tx_idx_q <= tx_idx_q + 3'd1;
                            if (tx_idx_q == 3'd7) begin
                                tx_state_q <= need_extra ? TX_EXTRA : TX_STOP;
                            end
                        end
                    end
                    TX_EXTRA: begin
                        if (bit_end) begin
                            tx_state_q <= TX_STOP;
                        end
                    end
                    default: begin
                        if (bit_end) begin
                            tx_stop_n_q <= 1'b0;
                            if (!tx_stop_n_q) begin
                                tx_state_q <= TX_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    assign rx_sample = tick & (rx_phase_q == `UCE_OVS_LAST);
    assign rx_done = (rx_state_q == RX_STOP) & rx_sample;
    assign kind = ctlb_q[`UCE_B_KIND_HI:`UCE_B_KIND_LO];

    always @* begin
        deliver = 1'b1;
        if (md_on) begin
            case (kind)
                2'b00: deliver = 1'b1;
                2'b01: deliver = rx_extra_q;
                2'b10: deliver = ~rx_extra_q & matched_q;
                default: deliver = rx_extra_q ? (rx_shift_q == adrcmp_q)
                    : matched_q;
            endcase
        end
    end

    always @(posedge CLK) begin
        if (RESET) begin
            rx_state_q <= RX_IDLE;
            rx_phase_q <= 4'h0;
            rx_idx_q <= 3'd0;
            rx_shift_q <= 8'h00;
            rx_extra_q <= 1'b0;
            matched_q <= 1'b0;
        end else if (!rx_on) begin
            rx_state_q <= RX_IDLE;
        end else begin
            if (tick) begin
                rx_phase_q <= rx_phase_q + 4'h1;
            end
            case (rx_state_q)
                RX_IDLE: begin
                    if (tick && !rx_bit) begin
                        rx_phase_q <= 4'h0;
                        rx_state_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick && rx_phase_q == `UCE_MID_BIT) begin
                        rx_phase_q <= 4'h0;
                        rx_idx_q <= 3'd0;
                        rx_extra_q <= 1'b0;
                        rx_state_q <= rx_bit ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift_q <= {rx_bit, rx_shift_q[7:1]};
                        rx_idx_q <= rx_idx_q + 3'd1;
                        if (rx_idx_q == 3'd7) begin
                            rx_state_q <= need_extra ? RX_EXTRA : RX_STOP;
                        end
                    end
                end
                RX_EXTRA: begin
                    if (rx_sample) begin
                        rx_extra_q <= rx_bit;
                        rx_state_q <= RX_STOP;
                    end
                end
                default: begin
                    if (rx_sample) begin
                        rx_state_q <= RX_IDLE;
                        if (md_on && rx_extra_q) begin
                            matched_q <= (rx_shift_q == adrcmp_q);
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave: answer one cycle after the request is seen
    // ------------------------------------------------------------------
    assign wr_take = WRITE & ~WAITREQUEST;
    assign rd_take = READ & ~WAITREQUEST;

    always @* begin
        rd_val = 8'h00;
        if (hit(ADDRESS, `UCE_IDX_DATA)) begin
            rd_val = rx_data_q;
        end else if (hit(ADDRESS, `UCE_IDX_STAT)) begin
            rd_val = {1'b0, ovr_q, frm_err_q, par_err_q, rx_addr_q,
                tx_state_q == TX_IDLE, ~tx_full_q, rx_avail_q};
        end else if (hit(ADDRESS, `UCE_IDX_CTLA)) begin
            rd_val = ctla_q;
        end else if (hit(ADDRESS, `UCE_IDX_CTLB)) begin
            rd_val = ctlb_q;
        end else if (hit(ADDRESS, `UCE_IDX_BAUDH)) begin
            rd_val = baud_q[15:8];
        end else if (hit(ADDRESS, `UCE_IDX_BAUDL)) begin
            rd_val = baud_q[7:0];
        end else if (hit(ADDRESS, `UCE_IDX_ADRCMP)) begin
            rd_val = adrcmp_q;
        end
    end

    always @(posedge CLK) begin
        if (RESET) begin
            WAITREQUEST <= 1'b1;
            READDATA <= 32'h0000_0000;
        end else if ((READ || WRITE) && WAITREQUEST) begin
            WAITREQUEST <= 1'b0;
            READDATA <= {24'h00_0000, READ ? rd_val : 8'h00};
        end else begin
            WAITREQUEST <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers and flags
    // ------------------------------------------------------------------
    always @(posedge CLK) begin
        if (RESET) begin
            ctla_q <= `UCE_CTLA_RST;
            ctlb_q <= `UCE_CTLB_RST;
            baud_q <= `UCE_BAUD_RST;
            adrcmp_q <= `UCE_ADRCMP_RST;
            tx_hold_q <= 8'h00;
            tx_full_q <= 1'b0;
            rx_data_q <= 8'h00;
            rx_addr_q <= 1'b0;
            rx_avail_q <= 1'b0;
            par_err_q <= 1'b0;
            frm_err_q <= 1'b0;
            ovr_q <= 1'b0;
            RX_IRQ <= 1'b0;
        end else begin
            if (tx_state_q == TX_IDLE && tx_full_q && tx_go && !brk) begin
                tx_full_q <= 1'b0;
            end
            if (wr_take && BYTEENABLE[0]) begin
                if (hit(ADDRESS, `UCE_IDX_DATA)) begin
                    if (!tx_full_q) begin
                        tx_hold_q <= WRITEDATA[7:0];
                        tx_full_q <= 1'b1;
                    end
                end else if (hit(ADDRESS, `UCE_IDX_STAT)) begin
                    if (WRITEDATA[`UCE_S_PAR_ERR]) par_err_q <= 1'b0;
                    if (WRITEDATA[`UCE_S_FRM_ERR]) frm_err_q <= 1'b0;
                    if (WRITEDATA[`UCE_S_OVERRUN]) ovr_q <= 1'b0;
                end else if (hit(ADDRESS, `UCE_IDX_CTLA)) begin
                    ctla_q <= WRITEDATA[7:0];
                end else if (hit(ADDRESS, `UCE_IDX_CTLB)) begin
                    ctlb_q <= WRITEDATA[7:0];
                end else if (hit(ADDRESS, `UCE_IDX_BAUDH)) begin
                    baud_q[15:8] <= WRITEDATA[7:0];
                end else if (hit(ADDRESS, `UCE_IDX_BAUDL)) begin
                    baud_q[7:0] <= WRITEDATA[7:0];
                end else if (hit(ADDRESS, `UCE_IDX_ADRCMP)) begin
                    adrcmp_q <= WRITEDATA[7:0];
                end
            end
            if (rd_take && hit(ADDRESS, `UCE_IDX_DATA)) begin
                rx_avail_q <= 1'b0;
            end
            // Completion events are placed last so a set beats a clear
            if (rx_done && rx_on) begin
                if (par_on && (rx_extra_q != (^rx_shift_q ^ par_odd))) begin
                    par_err_q <= 1'b1;
                end
                if (!rx_bit) begin
                    frm_err_q <= 1'b1;
                end
                if (deliver) begin
                    if (rx_avail_q && !(rd_take &&
                        hit(ADDRESS, `UCE_IDX_DATA))) begin
                        ovr_q <= 1'b1;
                    end else begin
                        rx_data_q <= rx_shift_q;
                        rx_addr_q <= md_on & rx_extra_q;
                        rx_avail_q <= 1'b1;
                    end
                end
            end
            RX_IRQ <= rx_on & ((rx_avail_q & ~ctlb_q[`UCE_B_ERR_ONLY])
                | par_err_q | frm_err_q | ovr_q);
        end
    end
endmodule // uce_serial_ctl

/* File: verification/tb_top.sv */
// Self-checking bench for the serial control block
`include "uce_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] all_m = 32'hffffffff;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [13:0] address = 14'h0000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'h1;
    logic cts_n = 1'b1;
    logic rxd;
    logic [31:0] readdata;
    logic waitrequest;
    logic txd;
    logic rx_irq;
    int err_total = 0;
    int n_compared = 0;
    always #20 clk = ~clk;
    uce_serial_ctl uut (
        .CLK(clk), .RESET(rst), .ADDRESS(address), .READ(read),
        .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable),
        .READDATA(readdata), .WAITREQUEST(waitrequest), .RXD(rxd),
        .CTS_N(cts_n), .TXD(txd), .RX_IRQ(rx_irq)
    );
    uce_far_node far (.clk(clk), .txd(txd), .rxd(rxd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] idx,
        input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        address <= {idx, 2'b00};
        write <= w;
        read <= !w;
        writedata <= {24'h000000, d};
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n == 50) begin
            err_total++;
            final_report();
        end
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task automatic rdc(input logic [11:0] idx, input logic [31:0] e,
        input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q & m, e);
    endtask
    task automatic t_tx;
        logic [10:0] f;
        logic ok;
        for (int m = 0; m < 3; m++) begin
            wr(`UCE_IDX_CTLA, m == 0 ? 8'h80 : (m == 1 ? 8'h90 : 8'h98));
            fork
                far.grab(f, ok);
                wr(`UCE_IDX_DATA, 8'hb5);
            join
            chk(ok, 1'b1);
            chk(f[9:0], {(m == 0 ? 1'b1 : ^8'hb5 ^ m[1]), 8'hb5, 1'b0});
            wr(`UCE_IDX_CTLA, 8'h00);
        end
    endtask
    task automatic t_cts;
        logic [10:0] f;
        logic ok;
        wr(`UCE_IDX_CTLA, 8'ha0);
        wr(`UCE_IDX_DATA, 8'h3c);
        repeat (300) @(posedge clk);
        chk(txd, 1'b1);
        fork
            far.grab(f, ok);
            cts_n <= 1'b0;
        join
        chk(f[9:0], {1'b1, 8'h3c, 1'b0});
        cts_n <= 1'b1;
        wr(`UCE_IDX_CTLA, 8'h00);
    endtask
    task automatic t_brk;
        wr(`UCE_IDX_CTLA, 8'h80);
        wr(`UCE_IDX_DATA, 8'h00);
        repeat (40) @(posedge clk);
        wr(`UCE_IDX_CTLA, 8'h84);
        repeat (4) @(posedge clk);
        chk(txd, 1'b0);
        wr(`UCE_IDX_CTLA, 8'h80);
        for (int i = 0; i < 6; i++) begin
            repeat (16) @(posedge clk);
            chk(txd, 1'b1);
        end
        wr(`UCE_IDX_CTLA, 8'h00);
    endtask
    task automatic rx_case(input logic [7:0] ca, input logic [7:0] cb,
        input logic [8:0] b, input int nb, input logic [7:0] st,
        input logic [7:0] m);
        wr(`UCE_IDX_CTLB, cb);
        wr(`UCE_IDX_CTLA, ca);
        if (cb[1]) begin
            far.send_ir(b, nb);
        end else begin
            far.send(b, nb);
        end
        chk(rx_irq, ca[6] & (st[0] & !cb[4] | st[4]));
        rdc(`UCE_IDX_STAT, {24'h000000, st & m}, {24'h000000, m});
        if (st[0]) begin
            rdc(`UCE_IDX_DATA, {24'h000000, b[7:0]}, all_m);
        end
        wr(`UCE_IDX_STAT, 8'h70);
        wr(`UCE_IDX_CTLA, 8'h00);
        wr(`UCE_IDX_CTLB, 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(`UCE_IDX_CTLA, 32'h00000000, all_m);
        wr(`UCE_IDX_CTLA, 8'h3a);
        rdc(`UCE_IDX_CTLA, 32'h0000003a, all_m);
        wr(`UCE_IDX_CTLA, 8'h00);
        rdc(12'hf47, 32'h00000000, all_m);
        t_tx;
        t_cts;
        t_brk;
        rx_case(8'h00, 8'h00, 9'h03c, 8, 8'h06, 8'hff);
        rx_case(8'h40, 8'h10, 9'h03c, 8, 8'h07, 8'hff);
        rx_case(8'h40, 8'h00, 9'h03c, 8, 8'h07, 8'hff);
        rx_case(8'h58, 8'h00, 9'h13c, 9, 8'h07, 8'hff);
        rx_case(8'h40, 8'ha0, 9'h03c, 9, 8'h06, 8'hff);
        rx_case(8'h40, 8'h80, 9'h13c, 9, 8'h0f, 8'hff);
        rx_case(8'h40, 8'he0, 9'h100, 9, 8'h0f, 8'hff);
        rx_case(8'h40, 8'h02, 9'h03c, 8, 8'h07, 8'hff);
        rx_case(8'h58, 8'h00, 9'h03c, 9, 8'h10, 8'h10);
        final_report;
    end
endmodule // tb_top

/* File: verification/uce_far_node.sv */
// Remote serial node: sends frames on its line and captures frames
module uce_far_node (
    input logic clk,
    input logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd = 1'b1;
    // Start bit, bits LSB first, then line high as stop and idle
    task automatic send(input logic [8:0] b, input int nb);
        rxd <= 1'b0;
        repeat (16) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            rxd <= b[i];
            repeat (16) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (32) @(posedge clk);
    endtask
    // Infrared line: a short low pulse opens each zero bit
    task automatic send_ir(input logic [8:0] b, input int nb);
        logic [9:0] f;
        f = {b, 1'b0};
        for (int i = 0; i <= nb; i++) begin
            rxd <= f[i];
            repeat (3) @(posedge clk);
            rxd <= 1'b1;
            repeat (13) @(posedge clk);
        end
        repeat (32) @(posedge clk);
    endtask
    // Samples eleven bit times in their middle after a falling edge
    task automatic grab(output logic [10:0] f, output logic ok);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        ok = (n < 3000);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd;
            repeat (16) @(posedge clk);
        end
    endtask
endmodule // uce_far_node

/* File: verification/uce_serial_chk.sv */
// Concurrent checks on bus timing, break, idle line and receiver request
module uce_serial_chk (
    input logic CLK,
    input logic RESET,
    input logic [13:0] ADDRESS,
    input logic READ,
    input logic WRITE,
    input logic [31:0] WRITEDATA,
    input logic [3:0] BYTEENABLE,
    input logic [31:0] READDATA,
    input logic WAITREQUEST,
    input logic CTS_N,
    input logic TXD,
    input logic RX_IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctl_q;
    logic ir_q;
    logic [8:0] quiet_q;
    logic wr_hit;
    logic quiet;
    assign wr_hit = WRITE && !WAITREQUEST && BYTEENABLE[0];
    assign quiet = !ctl_q[2] && !ir_q && (!ctl_q[7] || (ctl_q[5] && CTS_N));
    // Shadow of the control bits that steer the line
    always @(posedge CLK) begin
        if (RESET) begin
            ctl_q <= 8'h00;
            ir_q <= 1'b0;
        end else if (wr_hit && ADDRESS == 14'h3d08) begin
            ctl_q <= WRITEDATA[7:0];
        end else if (wr_hit && ADDRESS == 14'h3d0c) begin
            ir_q <= WRITEDATA[1];
        end
    end
    always @(posedge CLK) begin
        if (RESET || !quiet) begin
            quiet_q <= 9'h000;
        end else if (quiet_q != 9'h1ff) begin
            quiet_q <= quiet_q + 9'h001;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_wait_one:
        assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
        else $error("no answer one cycle after a request");
    a_wait_once:
        assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("answer longer than one cycle");
    a_wait_idle:
        assert property (!READ && !WRITE |=> WAITREQUEST)
        else $error("answer without a request");
    a_upper_zero:
        assert property (READDATA[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_ctl_back:
        assert property (READ && !WAITREQUEST && ADDRESS == 14'h3d08
            |-> READDATA == {24'h000000, ctl_q})
        else $error("control a reads back wrong");
    a_break_low:
        assert property (ctl_q[2] [*3] |-> !TXD)
        else $error("line not low during break");
    a_line_idle:
        assert property (quiet_q > 9'h104 |-> TXD)
        else $error("line active while transmitter off");
    a_irq_gate:
        assert property (!ctl_q[6] [*2] |-> !RX_IRQ)
        else $error("receiver request while receiver off");
endmodule // uce_serial_chk

bind uce_serial_ctl uce_serial_chk u_chk (
    .CLK(CLK), .RESET(RESET), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .CTS_N(CTS_N),
    .TXD(TXD), .RX_IRQ(RX_IRQ)
);
